//--- hw/bsas_top.sv
// Summary of operation
// - Operands shift out LSB first, one per clock.
// - Result shifts LSB first into output register.
// - Option, one-bit mode only: operand A register holds the result.
// - One-bit unit: full adder plus carry flop.
// - Carry flop cleared before every operation.
// - Each clock: sum bit out, carry stored.
// - One-bit mode takes WIDTH clocks.
// - Two-bit mode: separate odd/even operand registers.
// - Two-bit mode: two result bits, half clocks.
// - Two-bit mode: parallel sums, one carry stored.
// - Two-bit subtract: invert A in, result out.
// - Two-bit carry cleared for add and subtract.
// - Accumulator: result feeds next operation as A.
// - Parallel form: LSB carry input held zero.
`timescale 1ns/10ps
`default_nettype none
module bsas_top #(
    parameter int WIDTH = bsas_pkg::BSAS_WIDTH_DEF,
    parameter bit TWO_BIT = 1'b0,
    parameter bit SHARED_RESULT = 1'b0
) (
    input wire logic ref_clk_i, // Clock, 125 MHz.
    input wire logic srst_i, // Synchronous reset, active high.
    input wire logic start_i, // Request valid.
    output logic start_ready_o, // Buffer can take a request.
    input wire logic [WIDTH-1:0] opa_i, // Operand A.
    input wire logic [WIDTH-1:0] opb_i, // Operand B.
    input wire logic sub_i, // High selects A minus B.
    input wire logic use_acc_i, // Take A from the last result.
    output logic done_o, // One-cycle result valid.
    output logic [WIDTH-1:0] result_o, // Result word.
    output logic carry_o, // Final carry or borrow.
    output logic [WIDTH-1:0] par_sum_o // Parallel ripple sum.
);
    localparam int STEPS = TWO_BIT ? WIDTH / 2 : WIDTH;
    localparam int HW = (WIDTH + 1) / 2;
    localparam int CW = $clog2(STEPS + 1);

    initial begin
        if (TWO_BIT && (WIDTH % 2 != 0)) begin
            $error("WIDTH must be even in two-bit mode");
        end
    end

    typedef struct packed {
        logic [WIDTH-1:0] opa;
        logic [WIDTH-1:0] opb;
        logic sub;
        logic use_acc;
    } req_t;

    typedef struct packed {
        req_t [1:0] slot;
        logic [1:0] cnt;
        logic wr_ptr;
        logic rd_ptr;
        bsas_pkg::bsas_state_e st;
        logic [WIDTH-1:0] sa;
        logic [WIDTH-1:0] sb;
        logic [HW-1:0] ae;
        logic [HW-1:0] ao;
        logic [HW-1:0] be;
        logic [HW-1:0] bo;
        logic [WIDTH-1:0] res;
        logic [HW-1:0] re;
        logic [HW-1:0] ro;
        logic carry;
        logic sub;
        logic [CW-1:0] steps;
        logic done;
        logic [WIDTH-1:0] acc;
        logic [WIDTH-1:0] out;
        logic cout;
        logic [WIDTH-1:0] psum;
    } state_t;

    state_t s_reg;
    state_t s_next;
    req_t head;
    req_t wreq;
    logic push;
    logic pop;
    logic [WIDTH:0] rc;
    logic [WIDTH-1:0] a_ld;
    logic [WIDTH-1:0] word;
    logic fa_s;
    logic fa_c;
    logic ta;
    logic s0;
    logic s1;
    logic c0;
    logic c1;
    logic [WIDTH-1:0] psum_w;

    // Parallel ripple-carry form built by replicating the one-bit cell.
    // The carry flop is dropped and each carry feeds the next stage, so
    // the settling time grows with the width; it is registered before use.
    // The cell adds the last result to the accumulator, or subtracts the
    // accumulator from the last result when the last operation was a subtract.
    assign rc[0] = 1'b0;
    for (genvar i = 0; i < WIDTH; i++) begin : g_ripple
        logic ai;
        assign ai = s_reg.out[i] ^ s_reg.sub;
        assign psum_w[i] = s_reg.out[i] ^ s_reg.acc[i] ^ rc[i];
        assign rc[i+1] = (ai & s_reg.acc[i]) | (ai & rc[i])
            | (s_reg.acc[i] & rc[i]);
    end

    // Requests pass a two-entry buffer so that a request offered while the
    // engine is busy is not lost; the engine pops only when it is idle.
    // The serial engine loads, runs for STEPS clocks and then spends one
    // clock copying the finished word to the output registers.
    always_comb begin
        head = s_reg.slot[s_reg.rd_ptr];
        wreq.opa = opa_i;
        wreq.opb = opb_i;
        wreq.sub = sub_i;
        wreq.use_acc = use_acc_i;
        push = start_i && (s_reg.cnt != 2'h2);
        pop = (s_reg.cnt != 2'h0) && (s_reg.st == bsas_pkg::BSAS_ST_IDLE);
        a_ld = head.use_acc ? s_reg.acc : head.opa;
        // One-bit cell: A is inverted into the carry path only on subtract.
        fa_s = s_reg.sa[0] ^ s_reg.sb[0] ^ s_reg.carry;
        ta = s_reg.sa[0] ^ s_reg.sub;
        fa_c = (ta & s_reg.sb[0]) | (ta & s_reg.carry)
            | (s_reg.sb[0] & s_reg.carry);
        // Two-bit adder: both sums in parallel, one carry kept.
        s0 = s_reg.ae[0] ^ s_reg.be[0] ^ s_reg.carry;
        c0 = (s_reg.ae[0] & s_reg.be[0]) | (s_reg.ae[0] & s_reg.carry)
            | (s_reg.be[0] & s_reg.carry);
        s1 = s_reg.ao[0] ^ s_reg.bo[0] ^ c0;
        c1 = (s_reg.ao[0] & s_reg.bo[0]) | (s_reg.ao[0] & c0)
            | (s_reg.bo[0] & c0);
        word = SHARED_RESULT ? s_reg.sa : s_reg.res;
        if (TWO_BIT) begin
            for (int k = 0; k < HW; k++) begin
                word[2*k] = s_reg.re[k];
                if (2*k+1 < WIDTH) begin
                    word[2*k+1] = s_reg.ro[k];
                end
            end
        end
        s_next.slot = s_reg.slot;
        s_next.cnt = s_reg.cnt;
        s_next.wr_ptr = s_reg.wr_ptr;
        s_next.rd_ptr = s_reg.rd_ptr;
        s_next.st = s_reg.st;
        s_next.sa = s_reg.sa;
        s_next.sb = s_reg.sb;
        s_next.ae = s_reg.ae;
        s_next.ao = s_reg.ao;
        s_next.be = s_reg.be;
        s_next.bo = s_reg.bo;
        s_next.res = s_reg.res;
        s_next.re = s_reg.re;
        s_next.ro = s_reg.ro;
        s_next.carry = s_reg.carry;
        s_next.sub = s_reg.sub;
        s_next.steps = s_reg.steps;
        s_next.done = 1'b0;
        s_next.acc = s_reg.acc;
        s_next.out = s_reg.out;
        s_next.cout = s_reg.cout;
        s_next.psum = psum_w;
        if (push) begin
            s_next.slot[s_reg.wr_ptr] = wreq;
            s_next.wr_ptr = ~s_reg.wr_ptr;
        end
        case (s_reg.st)
            bsas_pkg::BSAS_ST_IDLE: begin
                if (pop) begin
                    s_next.rd_ptr = ~s_reg.rd_ptr;
                    s_next.sub = head.sub;
                    s_next.carry = bsas_pkg::BSAS_CARRY_RST;
                    s_next.sa = a_ld;
                    s_next.sb = head.opb;
                    s_next.steps = CW'(STEPS);
                    for (int k = 0; k < HW; k++) begin
                        // Subtract on the adder-only unit inverts A on load.
                        s_next.ae[k] = a_ld[2*k] ^ head.sub;
                        s_next.be[k] = head.opb[2*k];
                        s_next.ao[k] = (2*k+1 < WIDTH) ?
                            (a_ld[(2*k+1) % WIDTH] ^ head.sub) : 1'b0;
                        s_next.bo[k] = (2*k+1 < WIDTH) ?
                            head.opb[(2*k+1) % WIDTH] : 1'b0;
                    end
                    s_next.st = bsas_pkg::BSAS_ST_RUN;
                end
            end
            bsas_pkg::BSAS_ST_RUN: begin
                if (TWO_BIT) begin
                    s_next.ae = s_reg.ae >> 1;
                    s_next.ao = s_reg.ao >> 1;
                    s_next.be = s_reg.be >> 1;
                    s_next.bo = s_reg.bo >> 1;
                    // Result bits inverted on entry when subtracting.
                    s_next.re = {s0 ^ s_reg.sub, s_reg.re[HW-1:1]};
                    s_next.ro = {s1 ^ s_reg.sub, s_reg.ro[HW-1:1]};
                    s_next.carry = c1;
                end else begin
                    s_next.sb = s_reg.sb >> 1;
                    if (SHARED_RESULT) begin
                        s_next.sa = {fa_s, s_reg.sa[WIDTH-1:1]};
                    end else begin
                        s_next.sa = s_reg.sa >> 1;
                        s_next.res = {fa_s, s_reg.res[WIDTH-1:1]};
                    end
                    s_next.carry = fa_c;
                end
                s_next.steps = s_reg.steps - CW'(1);
                if (s_reg.steps == CW'(1)) begin
                    s_next.st = bsas_pkg::BSAS_ST_DONE;
                end
            end
            bsas_pkg::BSAS_ST_DONE: begin
                s_next.out = word;
                s_next.acc = word;
                s_next.cout = s_reg.carry;
                s_next.done = 1'b1;
                s_next.st = bsas_pkg::BSAS_ST_IDLE;
            end
            default: begin
                s_next.st = bsas_pkg::BSAS_ST_IDLE;
            end
        endcase
        s_next.cnt = s_reg.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign start_ready_o = (s_reg.cnt != 2'h2);
    assign done_o = s_reg.done;
    assign result_o = s_reg.out;
    assign carry_o = s_reg.cout;
    assign par_sum_o = s_reg.psum;

    logic [7:0] run_len;
    always_ff @(posedge ref_clk_i) begin
        if (srst_i || s_reg.st != bsas_pkg::BSAS_ST_RUN) begin
            run_len <= 8'h00;
        end else begin
            run_len <= run_len + 8'h01;
        end
    end

    carry_clear_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (s_reg.st == bsas_pkg::BSAS_ST_IDLE && pop) |=> !s_reg.carry)
        else $error("carry not cleared at load");
    run_length_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (s_reg.st == bsas_pkg::BSAS_ST_RUN && $past(s_reg.st)
        == bsas_pkg::BSAS_ST_IDLE) |-> ##(STEPS) s_reg.st
        == bsas_pkg::BSAS_ST_DONE)
        else $error("run length wrong");
    done_pulse_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        done_o |=> !done_o)
        else $error("done longer than one cycle");
    done_after_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        done_o |-> $past(s_reg.st) == bsas_pkg::BSAS_ST_DONE)
        else $error("done without completion");
    run_bound_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        run_len <= 8'(STEPS))
        else $error("run too long");
    acc_track_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        done_o |-> s_reg.acc == result_o)
        else $error("accumulator not updated");
    ripple_zero_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (s_reg.acc == '0 && !s_reg.sub) |=> par_sum_o == $past(s_reg.out))
        else $error("ripple carry in not zero");
    buf_full_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        s_reg.cnt <= 2'h2)
        else $error("buffer overfilled");

    // A load always starts the step counter at the full step count.
    steps_load_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (s_reg.st == bsas_pkg::BSAS_ST_IDLE && pop)
        |=> s_reg.steps == CW'(STEPS))
        else $error("step counter not loaded");

    // The step counter falls by one on every run clock.
    steps_count_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (s_reg.st == bsas_pkg::BSAS_ST_RUN && s_reg.steps != CW'(1))
        |=> s_reg.steps == $past(s_reg.steps) - CW'(1))
        else $error("step counter skipped");

    // The operation select is latched from the buffer head at load.
    sub_latch_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (s_reg.st == bsas_pkg::BSAS_ST_IDLE && pop)
        |=> s_reg.sub == $past(head.sub))
        else $error("operation select not latched");

    // Every accepted request advances the write pointer.
    push_ptr_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        push |=> s_reg.wr_ptr != $past(s_reg.wr_ptr))
        else $error("write pointer stuck");

    // The done pulse leaves the engine idle and ready for the next load.
    done_idle_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        done_o |-> s_reg.st == bsas_pkg::BSAS_ST_IDLE)
        else $error("done while busy");

    // An idle engine with nothing to load keeps its carry.
    idle_carry_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (s_reg.st == bsas_pkg::BSAS_ST_IDLE && !pop)
        |=> s_reg.carry == $past(s_reg.carry))
        else $error("carry changed while idle");

    // One-bit mode presents operand B one bit per clock, LSB first.
    shift_b_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (!TWO_BIT && s_reg.st == bsas_pkg::BSAS_ST_RUN)
        |=> s_reg.sb == ($past(s_reg.sb) >> 1))
        else $error("operand B not shifted");

    // Two-bit mode shifts the even and odd registers together.
    shift_pair_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (TWO_BIT && s_reg.st == bsas_pkg::BSAS_ST_RUN)
        |=> s_reg.ae == ($past(s_reg.ae) >> 1)
        && s_reg.bo == ($past(s_reg.bo) >> 1))
        else $error("operand pair not shifted");

    // Each sum bit enters the top of the result register.
    res_entry_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (!TWO_BIT && !SHARED_RESULT && s_reg.st == bsas_pkg::BSAS_ST_RUN)
        |=> s_reg.res[WIDTH-1] == $past(fa_s))
        else $error("sum bit lost");

    // One-bit mode stores the cell's carry for the next bit.
    carry_store_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (!TWO_BIT && s_reg.st == bsas_pkg::BSAS_ST_RUN)
        |=> s_reg.carry == $past(fa_c))
        else $error("carry not stored");

    // Two-bit mode stores only the carry of the upper bit.
    pair_carry_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (TWO_BIT && s_reg.st == bsas_pkg::BSAS_ST_RUN)
        |=> s_reg.carry == $past(c1))
        else $error("pair carry not stored");

    // The result word holds between completions.
    out_hold_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (s_reg.st != bsas_pkg::BSAS_ST_DONE) |=> $stable(result_o))
        else $error("result changed without done");
endmodule
`default_nettype wire

//--- hw/bsas_pkg.sv
package bsas_pkg;
    // Operation select: add or subtract.
    typedef enum logic {
        BSAS_OP_ADD,
        BSAS_OP_SUB
    } bsas_op_e;

    typedef enum logic [1:0] {
        BSAS_ST_IDLE,
        BSAS_ST_RUN,
        BSAS_ST_DONE
    } bsas_state_e;

    localparam int BSAS_WIDTH_DEF = 16;
    localparam logic BSAS_CARRY_RST = 1'h0;
    localparam int BSAS_BUF_DEPTH = 2;

    // Request word layout; not used, as bsas_top buffers its own req_t.
    typedef struct packed {
        logic [BSAS_WIDTH_DEF-1:0] opa;
        logic [BSAS_WIDTH_DEF-1:0] opb;
        bsas_op_e op;
        logic use_acc;
    } bsas_req_s;
endpackage

//--- verif/test_bit_serial_adder_subtractor.sv
`timescale 1ns/10ps
`default_nettype none
module test_bit_serial_adder_subtractor;
    localparam int W = bsas_pkg::BSAS_WIDTH_DEF;
    logic ref_clk = 1'b0;
    logic srst_i = 1'b1;
    logic start_i = 1'b0;
    logic sub_i = 1'b0;
    logic use_acc_i = 1'b0;
    logic [W-1:0] opa_i = '0;
    logic [W-1:0] opb_i = '0;
    logic [W-1:0] acc = '0;
    logic rdy0, rdy1, done0, done1, cy0, cy1, go;
    logic prev0 = 1'b0;
    logic prev1 = 1'b0;
    logic [W-1:0] res0, res1;
    logic rdy3, done3, cy3;
    logic sub0 = 1'b0;
    logic [W-1:0] res3, ps0;
    logic [W:0] e0;
    logic sq[$];
    logic [W:0] exp0[$];
    logic [W:0] exp1[$];
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    // All three engines take a request only at an edge where all three have room.
    assign go = start_i & rdy0 & rdy1 & rdy3;
    bsas_top #(.WIDTH(W), .TWO_BIT(1'b0), .SHARED_RESULT(1'b0)) i_dut (
        .ref_clk_i(ref_clk), .srst_i(srst_i), .start_i(go),
        .start_ready_o(rdy0), .opa_i(opa_i), .opb_i(opb_i), .sub_i(sub_i),
        .use_acc_i(use_acc_i), .done_o(done0), .result_o(res0),
        .carry_o(cy0), .par_sum_o(ps0));
    bsas_top #(.WIDTH(W), .TWO_BIT(1'b0), .SHARED_RESULT(1'b1)) i_dut3 (
        .ref_clk_i(ref_clk), .srst_i(srst_i), .start_i(go),
        .start_ready_o(rdy3), .opa_i(opa_i), .opb_i(opb_i), .sub_i(sub_i),
        .use_acc_i(use_acc_i), .done_o(done3), .result_o(res3),
        .carry_o(cy3), .par_sum_o());
    bsas_top #(.WIDTH(W), .TWO_BIT(1'b1), .SHARED_RESULT(1'b1)) i_dut2 (
        .ref_clk_i(ref_clk), .srst_i(srst_i), .start_i(go),
        .start_ready_o(rdy1), .opa_i(opa_i), .opb_i(opb_i), .sub_i(sub_i),
        .use_acc_i(use_acc_i), .done_o(done1), .result_o(res1),
        .carry_o(cy1), .par_sum_o());
    always #4 ref_clk = ~ref_clk;
    task automatic final_report();
        if (num_errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [W:0] seen, input logic [W:0] want);
        n_compared++;
        if (seen !== want) begin
            num_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    function automatic logic [W:0] model(input logic [W-1:0] a, b,
                                         input logic s);
        if (s) begin
            return {a < b, a - b};
        end
        return {1'b0, a} + {1'b0, b};
    endfunction
    always @(negedge ref_clk) begin
        if (done0 === 1'b1) begin
            e0 = exp0.size() ? exp0.pop_front() : 'x;
            sub0 = sq.size() ? sq.pop_front() : 1'bx;
            check({cy0, res0}, e0);
            check({cy3, res3}, e0);
            check((W+1)'(done3), (W+1)'(1'b1));
        end
        if (done1 === 1'b1) begin
            check({cy1, res1}, exp1.size() ? exp1.pop_front() : 'x);
        end
        if (prev0 === 1'b1) begin
            check((W+1)'(done0), '0);
            check((W+1)'(ps0), (W+1)'(sub0 ? W'(0) : W'(res0 << 1)));
        end
        if (prev1 === 1'b1) begin
            check((W+1)'(done1), '0);
        end
        prev0 <= done0;
        prev1 <= done1;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 6000) begin
            num_errors++;
            final_report();
        end
    end
    // Called at a rising edge; returns at the edge that took the request.
    task automatic put(input logic [W-1:0] a, b, input logic s, u);
        logic [W:0] e;
        logic r;
        int k;
        e = model(u ? acc : a, b, s);
        acc = e[W-1:0];
        exp0.push_back(e);
        exp1.push_back(e);
        sq.push_back(s);
        start_i <= 1'b1;
        opa_i <= a;
        opb_i <= b;
        sub_i <= s;
        use_acc_i <= u;
        k = 0;
        do begin
            #1 r = rdy0 & rdy1 & rdy3;
            @(posedge ref_clk);
            k++;
        end while (!r && k < 100);
        check((W+1)'(r), (W+1)'(1'b1));
    endtask
    task automatic one(input logic [W-1:0] a, b, input logic s, u);
        int n0, n1;
        n0 = 0;
        n1 = 0;
        put(a, b, s, u);
        start_i <= 1'b0;
        for (int n = 1; n <= 40; n++) begin
            @(posedge ref_clk);
            #1;
            if (done0 === 1'b1) n0 = n;
            if (done1 === 1'b1) n1 = n;
        end
        check((W+1)'(n0), (W+1)'(W + 2));
        check((W+1)'(n1), (W+1)'(W / 2 + 2));
        @(posedge ref_clk);
    endtask
    task automatic t_table();
        logic [2*W:0] tv[8] = '{{1'b0, 16'hffff, 16'h0001},
            {1'b0, 16'h0000, 16'h0000}, {1'b0, 16'h5555, 16'haaaa},
            {1'b1, 16'h0000, 16'h0001}, {1'b1, 16'h8000, 16'h7fff},
            {1'b1, 16'ha5a5, 16'ha5a5}, {1'b1, 16'h0001, 16'h0000},
            {1'b0, 16'hffff, 16'hffff}};
        // Carry, then zero operands: a stale carry would show in the sum.
        foreach (tv[i]) begin
            one(tv[i][2*W-1:W], tv[i][W-1:0], tv[i][2*W], 1'b0);
        end
    endtask
    task automatic t_acc();
        one(16'h0000, 16'h0010, 1'b0, 1'b0);
        one(16'hffff, 16'h0005, 1'b1, 1'b1);
        one(16'h0000, 16'h0001, 1'b0, 1'b1);
    endtask
    task automatic t_burst();
        put(16'h1234, 16'h0fff, 1'b0, 1'b0);
        put(16'h0001, 16'h0002, 1'b1, 1'b0);
        put(16'hfffe, 16'h0003, 1'b0, 1'b0);
        put(16'h8000, 16'h8000, 1'b1, 1'b0);
        start_i <= 1'b0;
        repeat (100) @(posedge ref_clk);
        check((W+1)'(exp0.size() + exp1.size()), '0);
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        srst_i <= 1'b0;
        @(posedge ref_clk);
        #1;
        check({cy0 | cy1, res0 | res1}, '0);
        check((W+1)'({rdy0, rdy1, done0, done1}), (W+1)'(4'hc));
        @(posedge ref_clk);
        t_table();
        t_acc();
        t_burst();
        final_report();
    end
endmodule
`default_nettype wire
